// ### hw/unm_cfg.svh
// Purpose: Constants for the unit number mapping and restart block
// Assumes: Word addresses are plain binary word numbers on the backplane
// Notes: Setup word offsets are relative to the first setup word
`ifndef UNM_CFG_SVH
`define UNM_CFG_SVH
`define UNM_CYC_BASE 16'd2000
`define UNM_CYC_WORDS 16'd10
`define UNM_SET_BASE 16'd20000
`define UNM_SET_WORDS 16'd100
`define UNM_UNIT_MAX 7'd95
`define UNM_OFS_USE 7'd0
`define UNM_OFS_RANGE 7'd1
`define UNM_OFS_HOLD 7'd2
`define UNM_USE_RST 16'h0000
`define UNM_RANGE_RST 16'h0000
`endif

// ### hw/unm_pkg.sv
// Purpose: Types for the unit number mapping and restart block
// Assumes: Nothing beyond the config header
// Notes: States are one-hot
package unm_pkg;
  typedef enum logic [2:0] {
    UNM_IDLE = 3'b001,
    UNM_LOAD = 3'b010,
    UNM_RUN = 3'b100
  } unm_state_type;
endpackage

// ### hw/unm_restart_if.sv
// Purpose: Carries the restart pulse between decoder and top
// Assumes: One clock domain
// Notes: Pulse lasts one cycle
`timescale 1ns/100ps
`default_nettype none
interface unm_restart_if;
  logic restartPulse; // One-cycle restart request
  logic bitLevel; // Synchronised restart bit
  modport src(output restartPulse, output bitLevel);
  modport dst(input restartPulse, input bitLevel);
endinterface
`default_nettype wire

// ### hw/unm_restart_det.sv
// Purpose: Picks this unit's restart bit and detects on-then-off
// Assumes: Restart words arrive from another clock domain
// Notes: Six words of sixteen bits, unit n at word n/16 bit n%16
`include "unm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module unm_restart_det
  import unm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [95:0] restartBits,
  input wire logic [6:0] unitNum,
  unm_restart_if.src rst
);
  // ----------------------------------------
  // Bit selection and synchroniser
  // ----------------------------------------
  logic [95:0] sync1_q; // First stage, read only by second
  logic [95:0] sync2_q; // Second stage
  logic prev_q; // Last level, for edge detect
  logic armed_q; // Bit has been seen on
  logic pulse_q; // Registered restart pulse
  logic selBit; // This unit's bit, packed 16 per word
  // Two flops on every bit, so no mux sits ahead of the synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= restartBits;
      sync2_q <= sync1_q;
    end
  end
  // A unit beyond the top of the range has no bit and never restarts
  assign selBit = (unitNum <= `UNM_UNIT_MAX) ? sync2_q[unitNum] : 1'b0; // [R6]
  // Level history for the on-then-off detect
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= selBit;
    end
  end
  // On then off: restart fires on the falling edge after an on
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= armed_q && prev_q && !selBit; // [R5]
      if (selBit) begin
        armed_q <= 1'b1;
      end else if (prev_q) begin
        armed_q <= 1'b0;
      end
    end
  end
  assign rst.restartPulse = pulse_q;
  assign rst.bitLevel = selBit;
  // Restart follows only after an on period
  property p_rst_after_on;
    @(posedge clk) disable iff (srst) $rose(pulse_q) |-> $past(selBit, 2);
  endproperty
  a_rst_after_on: assert property (p_rst_after_on) else $error("restart without on"); // [R5]
endmodule
`default_nettype wire

// ### hw/unm_unit_map.sv
// Purpose: Backplane window decode, setup load and channel control
// Assumes: Host word bus is synchronous to clk; switch is static
// Notes: Outputs are all registered
// How it works
// R1 - Cyclic window at 2000 plus ten times unit
// R2 - Setup window at 20000 plus hundred times unit
// R3 - Switch unit number 0..95 sets both windows
// R4 - Host flags duplicate unit numbers and stops
// R5 - Restart on restart bit on then off
// R6 - Restart bits sixteen per word, unit order
// R7 - Setup loads only at power-on or restart
// R8 - Setpoints exchange through cyclic window each refresh
// R9 - Host restarts after changing setup or errors
// R10 - Channel enabled only when use bit set
// R11 - Each channel takes its own range setting
// R12 - Ignore accesses outside both windows
`include "unm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module unm_unit_map
  import unm_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int RANGE_W = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [6:0] unitSwitch,
  input wire logic [95:0] restartBits,
  input wire logic busCycSel,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  output logic [15:0] busRdata,
  output logic busAck,
  output logic [15:0] setupReqAddr,
  output logic setupReqValid,
  output logic loadBusy,
  output logic unitBad,
  output logic [CHANNELS-1:0] chanEnable,
  output logic [CHANNELS*RANGE_W-1:0] chanRange,
  output logic [CHANNELS*16-1:0] chanSetpoint,
  output logic [CHANNELS*16-1:0] chanHold
);
  // ----------------------------------------
  // Unit number capture
  // ----------------------------------------
  logic [6:0] unit_q; // Unit number taken after reset
  logic capDone_q; // Switch read once per power-on
  logic unitBad_q; // Switch beyond 95
  logic [6:0] swMeta_q; // Switch first stage, read only by second
  logic [6:0] swSync_q; // Switch second stage
  // Panel pin passes two flops; left unreset so it has settled by release
  always_ff @(posedge clk) begin
    swMeta_q <= unitSwitch;
    swSync_q <= swMeta_q;
  end
  // Switch is read once after reset release, then held
  always_ff @(posedge clk) begin
    if (srst) begin
      unit_q <= 7'h00;
      capDone_q <= 1'b0;
      unitBad_q <= 1'b0;
    end else if (!capDone_q) begin
      unit_q <= swSync_q; // [R3]
      unitBad_q <= (swSync_q > `UNM_UNIT_MAX);
      capDone_q <= 1'b1;
    end
  end
  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  // Window bases are derived from the unit number alone
  function automatic logic [15:0] win_base(input logic [15:0] base, input logic [15:0] step,
                                           input logic [6:0] n);
    logic [31:0] prod;
    prod = 32'(step) * 32'(n);
    win_base = 16'(32'(base) + prod);
  endfunction
  logic [15:0] cycBase; // First cyclic word
  logic [15:0] setBase; // First setup word
  logic [15:0] cycOfs; // Offset into cyclic window
  logic [15:0] setOfs; // Offset into setup window
  logic cycHit; // Access lands in cyclic window
  logic setHit; // Access lands in setup window
  assign cycBase = win_base(`UNM_CYC_BASE, `UNM_CYC_WORDS, unit_q); // [R1]
  assign setBase = win_base(`UNM_SET_BASE, `UNM_SET_WORDS, unit_q); // [R2]
  assign cycOfs = busAddr - cycBase;
  assign setOfs = busAddr - setBase;
  assign cycHit = busCycSel && (busAddr >= cycBase) && (cycOfs < `UNM_CYC_WORDS); // [R1]
  assign setHit = !busCycSel && (busAddr >= setBase) && (setOfs < `UNM_SET_WORDS); // [R2]
  // ----------------------------------------
  // Restart detection
  // ----------------------------------------
  unm_restart_if rif();
  unm_restart_det u_det (
    .clk(clk),
    .srst(srst),
    .restartBits(restartBits),
    .unitNum(unit_q),
    .rst(rif.src)
  );
  // ----------------------------------------
  // Setup load sequencer
  // ----------------------------------------
  unm_state_type state_q; // Loader state
  logic [6:0] wordIdx_q; // Setup word being fetched
  logic [CHANNELS-1:0] useShadow_q; // Use bits as loaded
  logic [CHANNELS*RANGE_W-1:0] rangeShadow_q; // Ranges as loaded
  logic [CHANNELS*16-1:0] hold_q; // Hold values as loaded
  logic lastWord; // Final word of fixed data
  logic setWrite; // Host returns a setup word
  assign lastWord = (wordIdx_q == 7'(int'(`UNM_OFS_HOLD) + CHANNELS - 1));
  assign setWrite = setHit && busWr && (state_q == UNM_LOAD) && (setOfs[6:0] == wordIdx_q);
  // Load runs after reset with a valid unit and on a restart while running, never otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= UNM_IDLE;
      wordIdx_q <= 7'h00;
    end else begin
      unique case (state_q)
        UNM_IDLE: begin // Power-on load once unit is known
          if (capDone_q && !unitBad_q) begin
            state_q <= UNM_LOAD; // [R7]
            wordIdx_q <= `UNM_OFS_USE;
          end
        end
        UNM_LOAD: begin // Fetch words in order
          if (setWrite) begin
            if (lastWord) begin
              state_q <= UNM_RUN;
            end else begin
              wordIdx_q <= wordIdx_q + 7'h01;
            end
          end
        end
        UNM_RUN: begin // Only restart reloads
          if (rif.restartPulse) begin
            state_q <= UNM_LOAD; // [R7]
            wordIdx_q <= `UNM_OFS_USE;
          end
        end
      endcase
    end
  end
  // Capture setup words as the host supplies them
  always_ff @(posedge clk) begin
    if (srst) begin
      useShadow_q <= '0;
      rangeShadow_q <= '0;
      hold_q <= '0;
    end else if (setWrite) begin
      if (wordIdx_q == `UNM_OFS_USE) begin
        useShadow_q <= busWdata[CHANNELS-1:0];
      end else if (wordIdx_q == `UNM_OFS_RANGE) begin
        rangeShadow_q <= busWdata[CHANNELS*RANGE_W-1:0];
      end else begin
        hold_q[(int'(wordIdx_q) - int'(`UNM_OFS_HOLD))*16 +: 16] <= busWdata; // [R7]
      end
    end
  end
  // ----------------------------------------
  // Channel control
  // ----------------------------------------
  logic [CHANNELS-1:0] en_q; // Channel enables
  logic [CHANNELS*RANGE_W-1:0] range_q; // Channel ranges
  logic [CHANNELS*16-1:0] setpt_q; // Setpoints from cyclic window
  // Enables take effect only when running and are off while loading; ranges follow the loaded shadow at once
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      always_ff @(posedge clk) begin
        if (srst) begin
          en_q[g] <= 1'b0;
          range_q[g*RANGE_W +: RANGE_W] <= '0;
          setpt_q[g*16 +: 16] <= 16'h0000;
        end else begin
          en_q[g] <= (state_q == UNM_RUN) && useShadow_q[g]; // [R10]
          range_q[g*RANGE_W +: RANGE_W] <= rangeShadow_q[g*RANGE_W +: RANGE_W]; // [R11]
          if (cycHit && busWr && (cycOfs == 16'(g))) begin
            setpt_q[g*16 +: 16] <= busWdata; // [R8]
          end
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  logic [15:0] rdata_q; // Read data
  logic ack_q; // Access taken
  logic [15:0] reqAddr_q; // Setup word requested from host
  logic reqValid_q; // Request pending
  // Out-of-window accesses get no ack and no data
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      reqAddr_q <= 16'h0000;
      reqValid_q <= 1'b0;
    end else begin
      ack_q <= (cycHit || setHit) && (busWr || busRd); // [R12]
      if (cycHit && busRd) begin
        rdata_q <= (cycOfs < 16'(CHANNELS)) ? setpt_q[cycOfs[3:0]*16 +: 16] : 16'h0000; // [R8]
      end else begin
        rdata_q <= 16'h0000; // [R12]
      end
      reqValid_q <= (state_q == UNM_LOAD) && !setWrite;
      reqAddr_q <= setBase + 16'(wordIdx_q);
    end
  end
  assign busRdata = rdata_q;
  assign busAck = ack_q;
  assign setupReqAddr = reqAddr_q;
  assign setupReqValid = reqValid_q;
  assign loadBusy = state_q[1];
  assign unitBad = unitBad_q;
  assign chanEnable = en_q;
  assign chanRange = range_q;
  assign chanSetpoint = setpt_q;
  assign chanHold = hold_q;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_restart;
    rif.restartPulse && state_q == UNM_RUN;
  endsequence
  property p_reload;
    @(posedge clk) disable iff (srst) s_restart |=> state_q == UNM_LOAD && wordIdx_q == 7'h00;
  endproperty
  a_reload: assert property (p_reload) else $error("restart did not reload"); // [R7]
  property p_restart_off;
    @(posedge clk) disable iff (srst) rif.restartPulse |-> !$past(rif.bitLevel);
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("restart while bit on"); // [R5]
  property p_no_load_run;
    @(posedge clk) disable iff (srst)
      state_q == UNM_RUN && !rif.restartPulse |=> state_q == UNM_RUN;
  endproperty
  a_no_load_run: assert property (p_no_load_run) else $error("load without restart"); // [R7]
  property p_ack_window;
    @(posedge clk) disable iff (srst) busAck |-> $past(cycHit || setHit);
  endproperty
  a_ack_window: assert property (p_ack_window) else $error("ack outside window"); // [R12]
  property p_cyc_base;
    @(posedge clk) disable iff (srst) capDone_q |-> cycBase == 16'(2000 + 10 * int'(unit_q));
  endproperty
  a_cyc_base: assert property (p_cyc_base) else $error("cyclic base wrong"); // [R1]
  property p_set_base;
    @(posedge clk) disable iff (srst) capDone_q |-> setBase == 16'(20000 + 100 * int'(unit_q));
  endproperty
  a_set_base: assert property (p_set_base) else $error("setup base wrong"); // [R2]
  property p_unit_stable;
    @(posedge clk) disable iff (srst) capDone_q |=> $stable(unit_q);
  endproperty
  a_unit_stable: assert property (p_unit_stable) else $error("unit changed"); // [R3]
  property p_enable_use;
    @(posedge clk) disable iff (srst) en_q[0] |-> $past(useShadow_q[0] && state_q == UNM_RUN);
  endproperty
  a_enable_use: assert property (p_enable_use) else $error("channel on without use"); // [R10]
  property p_range;
    @(posedge clk) disable iff (srst) ##1 range_q == $past(rangeShadow_q);
  endproperty
  a_range: assert property (p_range) else $error("range not applied"); // [R11]
  property p_setpoint;
    @(posedge clk) disable iff (srst)
      cycHit && busWr && cycOfs == 16'h0000 |=> setpt_q[15:0] == $past(busWdata);
  endproperty
  a_setpoint: assert property (p_setpoint) else $error("setpoint not stored"); // [R8]
endmodule
`default_nettype wire

// ### tb/unm_host_model.sv
// Purpose: Host side of the backplane, bus master and restart bits
// Assumes: One clock; strobes last one cycle
// Notes: Setup words pushed in offset order from setupMem
`timescale 1ns/100ps
`default_nettype none
module unm_host_model (
  input wire logic clk,
  input wire logic [15:0] busRdata,
  input wire logic busAck,
  input wire logic loadBusy,
  output logic [95:0] restartBits,
  output logic busCycSel,
  output logic busWr,
  output logic busRd,
  output logic [15:0] busAddr,
  output logic [15:0] busWdata
);
  // -----------------------------
  // Host memory and drivers
  // -----------------------------
  logic [15:0] setupMem [0:9]; // Host copy of the setup words
  initial begin
    restartBits = '0;
    busCycSel = 1'b0;
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = '0;
    busWdata = '0;
  end
  // One access; answer read mid-cycle after the taking edge
  task automatic access(input logic cyc, input logic wr, input logic [15:0] addr,
      input logic [15:0] wd, output logic ack, output logic [15:0] rd);
    @(posedge clk);
    busCycSel <= cyc;
    busWr <= wr;
    busRd <= !wr;
    busAddr <= addr;
    busWdata <= wd;
    @(posedge clk);
    busWr <= 1'b0;
    busRd <= 1'b0;
    @(negedge clk);
    ack = busAck;
    rd = busRdata;
  endtask
  // Bit on, held, then off; one bit a unit, sixteen a word
  task automatic restart(input int unit, input int hi);
    @(posedge clk);
    restartBits[unit] <= 1'b1;
    repeat (hi) @(posedge clk);
    restartBits[unit] <= 1'b0;
  endtask
  // Waits for the load, then pushes all setup words in order
  task automatic loadSetup(input logic [6:0] n, output logic ok);
    logic ack;
    logic [15:0] rd;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge clk);
      ok = loadBusy;
    end
    for (int i = 0; i < 10; i++) begin
      access(1'b0, 1'b1, 16'd20000 + 16'd100 * n + 16'(i), setupMem[i], ack, rd);
    end
  endtask
  // Duplicate unit numbers are caught on the host; one unit here
endmodule
`default_nettype wire

// ### tb/test_unm_unit_map.sv
// Purpose: Checks windows, setup load and restart of the unit map
// Assumes: Default of eight channels, two range bits each
// Notes: Bus traffic goes through the host model tasks
`timescale 1ns/100ps
`default_nettype none
module test_unit_number_mapping_and_restart;
  // -----------------------------
  // Signals and instances
  // -----------------------------
  logic clk, srst, ok, ack;
  logic [6:0] unitSwitch;
  logic [95:0] restartBits;
  logic busCycSel, busWr, busRd, busAck, setupReqValid, loadBusy, unitBad;
  logic [15:0] busAddr, busWdata, busRdata, setupReqAddr, rd;
  logic [7:0] chanEnable;
  logic [15:0] chanRange;
  logic [127:0] chanSetpoint, chanHold, expSet, expHold;
  int errTotal, nTests;
  logic [16:0] winTab [0:5]; // Cyclic flag and address
  logic winAck [0:5]; // Expected ack per entry
  unm_unit_map DUT (.clk(clk), .srst(srst), .unitSwitch(unitSwitch),
    .restartBits(restartBits), .busCycSel(busCycSel), .busWr(busWr), .busRd(busRd),
    .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .busAck(busAck),
    .setupReqAddr(setupReqAddr), .setupReqValid(setupReqValid), .loadBusy(loadBusy),
    .unitBad(unitBad), .chanEnable(chanEnable), .chanRange(chanRange),
    .chanSetpoint(chanSetpoint), .chanHold(chanHold));
  unm_host_model host (.clk(clk), .busRdata(busRdata), .busAck(busAck),
    .loadBusy(loadBusy), .restartBits(restartBits), .busCycSel(busCycSel),
    .busWr(busWr), .busRd(busRd), .busAddr(busAddr), .busWdata(busWdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // -----------------------------
  // Check and end tasks
  // -----------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic stopTest();
    if (errTotal == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Timed-out waits end the run at once
  task automatic need(input logic r);
    check(r, 1'b1);
    if (r !== 1'b1) stopTest();
  endtask
  // Reset for twenty cycles with a given switch setting
  task automatic doReset(input logic [6:0] n);
    @(posedge clk);
    srst <= 1'b1;
    unitSwitch <= n;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
  endtask
  // -----------------------------
  // Main sequence
  // -----------------------------
  initial begin
    srst = 1'b1;
    unitSwitch = 7'd3;
    host.setupMem[0] = 16'h00a5;
    host.setupMem[1] = 16'h1b4e;
    for (int k = 0; k < 8; k++) begin
      host.setupMem[k + 2] = 16'h0102 + 16'(k);
      expHold[k * 16 +: 16] = 16'h0102 + 16'(k);
      expSet[k * 16 +: 16] = 16'h0a00 + 16'(k);
    end
    winTab = '{{1'b1, 16'd2029}, {1'b1, 16'd2039}, {1'b1, 16'd2040},
      {1'b0, 16'd20299}, {1'b0, 16'd20399}, {1'b0, 16'd20400}};
    winAck = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    doReset(7'd3);
    host.loadSetup(7'd3, ok);
    need(ok);
    repeat (3) @(negedge clk);
    check(chanEnable, 8'ha5);
    check(chanRange, 16'h1b4e);
    check(chanHold, expHold);
    // Setpoints in, then read back
    for (int k = 0; k < 8; k++) begin
      host.access(1'b1, 1'b1, 16'd2030 + 16'(k), expSet[k * 16 +: 16], ack, rd);
    end
    for (int k = 0; k < 8; k++) begin
      host.access(1'b1, 1'b0, 16'd2030 + 16'(k), 16'h0000, ack, rd);
      check({ack, rd}, {1'b1, expSet[k * 16 +: 16]});
    end
    check(chanSetpoint, expSet);
    // Window edges; misses read as zero
    for (int k = 0; k < 6; k++) begin
      host.access(winTab[k][16], 1'b0, winTab[k][15:0], 16'h0000, ack, rd);
      check(ack, winAck[k]);
      if (k != 1) check(rd, 16'h0000);
    end
    // New setup ignored while running
    host.setupMem[0] = 16'h003c;
    host.access(1'b0, 1'b1, 16'd20300, 16'h003c, ack, rd);
    repeat (3) @(negedge clk);
    check(chanEnable, 8'ha5);
    // Another unit's bit does nothing
    host.restart(19, 6);
    repeat (12) @(negedge clk);
    check(loadBusy, 1'b0);
    // Bit on alone does not restart; off does
    host.restart(3, 6);
    @(negedge clk);
    check(loadBusy, 1'b0);
    host.loadSetup(7'd3, ok);
    need(ok);
    repeat (3) @(negedge clk);
    check(chanEnable, 8'h3c);
    // Highest unit number
    doReset(7'd95);
    repeat (4) @(negedge clk);
    check({setupReqValid, setupReqAddr}, {1'b1, 16'd29500});
    host.loadSetup(7'd95, ok);
    need(ok);
    repeat (3) @(negedge clk);
    check(chanEnable, 8'h3c);
    host.access(1'b1, 1'b0, 16'd2959, 16'h0000, ack, rd);
    check(ack, 1'b1);
    host.access(1'b1, 1'b0, 16'd2960, 16'h0000, ack, rd);
    check(ack, 1'b0);
    // Out-of-range switch never loads
    doReset(7'd96);
    repeat (10) @(negedge clk);
    check({unitBad, loadBusy, setupReqValid}, 3'b100);
    stopTest();
  end
endmodule
`default_nettype wire
